// ---- core/imu_consts.vh ----
// Constants of the integer multiply unit: opcode fields, encodings and flag positions.
`ifndef IMU_CONSTS_VH
`define IMU_CONSTS_VH
`define IMU_WORD_OPC 4'hc
`define IMU_WORD_OPC_HI 15
`define IMU_WORD_OPC_LO 12
`define IMU_WORD_REG_HI 11
`define IMU_WORD_REG_LO 9
`define IMU_WORD_OPM_HI 8
`define IMU_WORD_OPM_LO 6
`define IMU_OPM_SIGNED 3'h7
`define IMU_OPM_UNSIGNED 3'h3
`define IMU_LONG_OPC 10'h130
`define IMU_LONG_OPC_HI 15
`define IMU_LONG_OPC_LO 6
`define IMU_EXT_LOW_HI 14
`define IMU_EXT_LOW_LO 12
`define IMU_EXT_SIGN_BIT 11
`define IMU_EXT_SIZE_BIT 10
`define IMU_EXT_HIGH_HI 2
`define IMU_EXT_HIGH_LO 0
`define IMU_EA_MODE_HI 5
`define IMU_EA_MODE_LO 3
`define IMU_EA_REG_HI 2
`define IMU_EA_REG_LO 0
`define IMU_MODE_DREG 3'h0
`define IMU_MODE_AREG 3'h1
`define IMU_MODE_EXT 3'h7
`define IMU_EXT_ABSW 3'h0
`define IMU_EXT_ABSL 3'h1
`define IMU_EXT_PCD16 3'h2
`define IMU_EXT_PCIDX 3'h3
`define IMU_EXT_IMM 3'h4
`define IMU_CCR_C 0
`define IMU_CCR_V 1
`define IMU_CCR_Z 2
`define IMU_CCR_N 3
`define IMU_CCR_X 4
`define IMU_CCR_RST 5'h00
`endif

// ---- core/imu_mult_core.v ----
// Multi-cycle shift-add multiplier for signed and unsigned 32x32 operands.
`timescale 1ns/1ps
`include "imu_consts.vh"
module imu_mult_core #(
  parameter WIDTH = 32
) (
  clk,
  sys_rst,
  clkEn,
  start,
  signedOp,
  opA,
  opB,
  busy,
  done,
  product
);
  input wire clk;
  input wire sys_rst;
  input wire clkEn;
  input wire start;
  input wire signedOp;
  input wire [WIDTH-1:0] opA;
  input wire [WIDTH-1:0] opB;
  output wire busy;
  output reg done;
  output reg [2*WIDTH-1:0] product;

  localparam CW = 7;
  localparam [31:0] STEPS = WIDTH;
  reg [CW-1:0] count_r;
  reg busy_r;
  reg neg_r;
  reg [WIDTH-1:0] mcand_r;
  reg [2*WIDTH-1:0] acc_r;
  reg [WIDTH:0] sum;

  // Magnitude of an operand, taking its sign into account when signed.
  function [WIDTH-1:0] magOf;
    input [WIDTH-1:0] v;
    input sgn;
    begin
      if (sgn && v[WIDTH-1]) begin
        magOf = ~v + {{(WIDTH-1){1'b0}}, 1'b1};
      end else begin
        magOf = v;
      end
    end
  endfunction

  assign busy = busy_r;

  always @* begin
    sum = {1'b0, acc_r[2*WIDTH-1:WIDTH]};
    if (acc_r[0]) begin
      sum = {1'b0, acc_r[2*WIDTH-1:WIDTH]} + {1'b0, mcand_r};
    end
  end

  // Operands become magnitudes; the sign is reapplied once the product is complete.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= 7'h00;
      busy_r <= 1'b0;
      neg_r <= 1'b0;
      mcand_r <= {WIDTH{1'b0}};
      acc_r <= {(2*WIDTH){1'b0}};
      done <= 1'b0;
      product <= {(2*WIDTH){1'b0}};
    end else if (clkEn) begin
      done <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        count_r <= STEPS[CW-1:0];
        neg_r <= signedOp & (opA[WIDTH-1] ^ opB[WIDTH-1]);
        mcand_r <= magOf(opA, signedOp);
        acc_r <= {{WIDTH{1'b0}}, magOf(opB, signedOp)};
      end else if (busy_r) begin
        if (count_r == 7'h00) begin
          busy_r <= 1'b0;
          done <= 1'b1;
          if (neg_r) begin
            product <= ~acc_r + {{(2*WIDTH-1){1'b0}}, 1'b1};
          end else begin
            product <= acc_r;
          end
        end else begin
          acc_r <= {sum, acc_r[WIDTH-1:1]};
          count_r <= count_r - 7'h01;
        end
      end
    end
  end
endmodule

// ---- core/imu_multiply_unit.v ----
// Integer multiply unit: decode, operand select, register writeback and flags.
//
// Contract
// - The signed multiply treats both operands as two's complement and yields a signed product.
// - The unsigned multiply treats both operands as unsigned and yields an unsigned product.
// - The word form uses only the low 16 bits of a register operand and writes all 32 bits.
// - A 32-bit long-form result keeps the low 32 bits of the 64-bit product.
// - Negative follows the result sign, zero marks an all-zero result, carry clears, extend holds.
// - Overflow can be set only by the long form with a 32-bit result, else it clears.
// - Signed 32-bit result overflows when the upper half is not the sign extension of bit 31.
// - Unsigned 32-bit result overflows when any upper-half bit is one.
// - Word form bits 11..9 name the destination and bits 8..6 give 111 signed, 011 unsigned.
// - In the long form the low-product register supplies the multiplicand and takes the low half.
// - Size 0 returns 32 bits to the low-product register, size 1 returns 64 bits over two.
// - A 64-bit result puts the high half in the high-product register; equal fields are undefined.
// - The source comes from a data addressing mode, never address register direct.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "imu_consts.vh"
module imu_multiply_unit #(
  parameter WIDTH = 32
) (
  clk,
  sys_rst,
  clkEn,
  issue,
  opWord,
  extWord,
  eaOperand,
  ccrIn,
  regRdIdxA,
  regRdDataA,
  regRdIdxB,
  regRdDataB,
  busy,
  accept,
  illegal,
  done,
  regWrEnLow,
  regWrIdxLow,
  regWrDataLow,
  regWrEnHigh,
  regWrIdxHigh,
  regWrDataHigh,
  ccrWrEn,
  ccrOut
);
  input wire clk;
  input wire sys_rst;
  input wire clkEn;
  input wire issue;
  input wire [15:0] opWord;
  input wire [15:0] extWord;
  input wire [WIDTH-1:0] eaOperand;
  input wire [4:0] ccrIn;
  output wire [2:0] regRdIdxA;
  input wire [WIDTH-1:0] regRdDataA;
  output wire [2:0] regRdIdxB;
  input wire [WIDTH-1:0] regRdDataB;
  output wire busy;
  output wire accept;
  output wire illegal;
  output reg done;
  output reg regWrEnLow;
  output reg [2:0] regWrIdxLow;
  output reg [WIDTH-1:0] regWrDataLow;
  output reg regWrEnHigh;
  output reg [2:0] regWrIdxHigh;
  output reg [WIDTH-1:0] regWrDataHigh;
  output reg ccrWrEn;
  output reg [4:0] ccrOut;

  localparam HALF = WIDTH / 2;
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_WB = 2'h2;

  // ====================================================================
  // Decode
  // ====================================================================
  wire [2:0] eaMode;
  wire [2:0] eaReg;
  wire [2:0] opMode;
  wire isWord;
  wire isLong;
  wire eaOk;
  wire wordSigned;
  wire longSigned;
  wire longSize;
  wire [2:0] lowIdx;
  wire [2:0] highIdx;
  wire [2:0] wordDst;

  // Data addressing modes: everything except address register direct and reserved codes.
  function eaIsData;
    input [2:0] mode;
    input [2:0] reg3;
    begin
      if (mode == `IMU_MODE_AREG) begin
        eaIsData = 1'b0;
      end else if (mode == `IMU_MODE_EXT) begin
        eaIsData = (reg3 == `IMU_EXT_ABSW) || (reg3 == `IMU_EXT_ABSL) ||
          (reg3 == `IMU_EXT_PCD16) || (reg3 == `IMU_EXT_PCIDX) ||
          (reg3 == `IMU_EXT_IMM);
      end else begin
        eaIsData = 1'b1;
      end
    end
  endfunction

  assign eaMode = opWord[`IMU_EA_MODE_HI:`IMU_EA_MODE_LO];
  assign eaReg = opWord[`IMU_EA_REG_HI:`IMU_EA_REG_LO];
  assign opMode = opWord[`IMU_WORD_OPM_HI:`IMU_WORD_OPM_LO];
  assign wordDst = opWord[`IMU_WORD_REG_HI:`IMU_WORD_REG_LO];
  assign eaOk = eaIsData(eaMode, eaReg);
  assign isWord = (opWord[`IMU_WORD_OPC_HI:`IMU_WORD_OPC_LO] == `IMU_WORD_OPC) &&
    ((opMode == `IMU_OPM_SIGNED) || (opMode == `IMU_OPM_UNSIGNED));
  assign isLong = (opWord[`IMU_LONG_OPC_HI:`IMU_LONG_OPC_LO] == `IMU_LONG_OPC) &&
    (extWord[15] == 1'b0) && (extWord[9:3] == 7'h00);
  assign wordSigned = (opMode == `IMU_OPM_SIGNED);
  assign longSigned = extWord[`IMU_EXT_SIGN_BIT];
  assign longSize = extWord[`IMU_EXT_SIZE_BIT];
  assign lowIdx = extWord[`IMU_EXT_LOW_HI:`IMU_EXT_LOW_LO];
  assign highIdx = extWord[`IMU_EXT_HIGH_HI:`IMU_EXT_HIGH_LO];

  // ====================================================================
  // Operand selection
  // ====================================================================
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg wordForm_r;
  reg signed_r;
  reg size64_r;
  reg [2:0] lowIdx_r;
  reg [2:0] highIdx_r;
  reg [WIDTH-1:0] srcFull;
  reg [WIDTH-1:0] opA;
  reg [WIDTH-1:0] opB;
  wire idle;
  wire startMul;
  wire mulBusy;
  wire mulDone;
  wire [2*WIDTH-1:0] product;

  assign idle = (state_r == ST_IDLE);
  assign busy = !idle;
  assign regRdIdxA = isWord ? wordDst : lowIdx;
  assign regRdIdxB = eaReg;
  assign illegal = idle && issue && !((isWord || isLong) && eaOk);
  assign accept = idle && issue && (isWord || isLong) && eaOk;
  assign startMul = accept && clkEn;

  // Word operands are sign or zero extended from bit 15; upper halves are dropped.
  function [WIDTH-1:0] wordExt;
    input [WIDTH-1:0] v;
    input sgn;
    begin
      wordExt = {{HALF{sgn & v[HALF-1]}}, v[HALF-1:0]};
    end
  endfunction

  always @* begin
    srcFull = eaOperand;
    if (eaMode == `IMU_MODE_DREG) begin
      srcFull = regRdDataB;
    end
    if (isWord) begin
      opA = wordExt(regRdDataA, wordSigned);
      opB = wordExt(srcFull, wordSigned);
    end else begin
      opA = regRdDataA;
      opB = srcFull;
    end
  end

  imu_mult_core #(
    .WIDTH(WIDTH)
  ) u_core (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .start(startMul),
    .signedOp(isWord ? wordSigned : longSigned),
    .opA(opA),
    .opB(opB),
    .busy(mulBusy),
    .done(mulDone),
    .product(product)
  );

  // ====================================================================
  // Control
  // ====================================================================
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (mulDone) begin
          state_nxt = ST_WB;
        end
      end
      ST_WB: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      wordForm_r <= 1'b0;
      signed_r <= 1'b0;
      size64_r <= 1'b0;
      lowIdx_r <= 3'h0;
      highIdx_r <= 3'h0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      if (accept) begin
        wordForm_r <= isWord;
        signed_r <= isWord ? wordSigned : longSigned;
        size64_r <= isLong & longSize;
        lowIdx_r <= isWord ? wordDst : lowIdx;
        highIdx_r <= highIdx;
      end
    end
  end

  // ====================================================================
  // Result and flags
  // ====================================================================
  wire [WIDTH-1:0] lowHalf;
  wire [WIDTH-1:0] highHalf;
  wire ovfSigned;
  wire ovfUnsigned;
  wire ovf;
  wire resNeg;
  wire resZero;

  assign lowHalf = product[WIDTH-1:0];
  assign highHalf = product[2*WIDTH-1:WIDTH];
  assign ovfSigned = (highHalf != {WIDTH{lowHalf[WIDTH-1]}});
  assign ovfUnsigned = (highHalf != {WIDTH{1'b0}});
  assign ovf = !wordForm_r && !size64_r && (signed_r ? ovfSigned : ovfUnsigned);
  assign resNeg = size64_r ? highHalf[WIDTH-1] : lowHalf[WIDTH-1];
  assign resZero = size64_r ? (product == {(2*WIDTH){1'b0}}) :
    (lowHalf == {WIDTH{1'b0}});

  // Outputs update only from the finished product, a single cycle after it lands.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
      regWrEnLow <= 1'b0;
      regWrIdxLow <= 3'h0;
      regWrDataLow <= {WIDTH{1'b0}};
      regWrEnHigh <= 1'b0;
      regWrIdxHigh <= 3'h0;
      regWrDataHigh <= {WIDTH{1'b0}};
      ccrWrEn <= 1'b0;
      ccrOut <= `IMU_CCR_RST;
    end else if (clkEn) begin
      done <= 1'b0;
      regWrEnLow <= 1'b0;
      regWrEnHigh <= 1'b0;
      ccrWrEn <= 1'b0;
      if (state_r == ST_RUN && mulDone) begin
        done <= 1'b1;
        regWrEnLow <= 1'b1;
        regWrIdxLow <= lowIdx_r;
        regWrDataLow <= lowHalf;
        regWrEnHigh <= size64_r;
        regWrIdxHigh <= highIdx_r;
        regWrDataHigh <= highHalf;
        ccrWrEn <= 1'b1;
        ccrOut[`IMU_CCR_X] <= ccrIn[`IMU_CCR_X];
        ccrOut[`IMU_CCR_N] <= resNeg;
        ccrOut[`IMU_CCR_Z] <= resZero;
        ccrOut[`IMU_CCR_V] <= ovf;
        ccrOut[`IMU_CCR_C] <= 1'b0;
      end
    end
  end
endmodule

// ---- verification/imu_regfile_model.sv ----
// Model of the core's eight data registers that feed and receive the multiply unit.
`timescale 1ns/1ps
module imu_regfile_model (
  input wire logic clk,
  input wire logic [2:0] rdIdxA,
  output wire logic [31:0] rdDataA,
  input wire logic [2:0] rdIdxB,
  output wire logic [31:0] rdDataB,
  input wire logic wrEnLow,
  input wire logic [2:0] wrIdxLow,
  input wire logic [31:0] wrDataLow,
  input wire logic wrEnHigh,
  input wire logic [2:0] wrIdxHigh,
  input wire logic [31:0] wrDataHigh
);
  logic [31:0] dreg [8];
  initial begin
    foreach (dreg[i]) dreg[i] = 32'h0;
  end
  assign rdDataA = dreg[rdIdxA];
  assign rdDataB = dreg[rdIdxB];
  // The high write lands last, so equal indices leave whatever the unit sent high.
  always @(posedge clk) begin
    if (wrEnLow) dreg[wrIdxLow] <= wrDataLow;
    if (wrEnHigh) dreg[wrIdxHigh] <= wrDataHigh;
  end
endmodule

// ---- verification/imu_mult_checker.sv ----
// Checker of the multiply unit's timing, writeback strobes and flags.
`timescale 1ns/1ps
module imu_mult_checker #(
  parameter WIDTH = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] opWord,
  input wire logic busy,
  input wire logic accept,
  input wire logic illegal,
  input wire logic done,
  input wire logic regWrEnLow,
  input wire logic [WIDTH-1:0] regWrDataLow,
  input wire logic regWrEnHigh,
  input wire logic [WIDTH-1:0] regWrDataHigh,
  input wire logic ccrWrEn,
  input wire logic [4:0] ccrOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence sWb;
    done && regWrEnLow && ccrWrEn;
  endsequence
  sequence sQuiet;
    busy && !done && !regWrEnLow && !ccrWrEn;
  endsequence
  AST_LATENCY: assert property (accept |-> ##35 sWb)
    else $error("writeback not seen 35 cycles after accept");
  AST_NO_EARLY: assert property (accept |=> sQuiet [*8])
    else $error("result visible while the product is incomplete");
  AST_HIGH_PAIR: assert property (regWrEnHigh |-> sWb)
    else $error("high write without the low write");
  AST_CARRY: assert property (ccrWrEn |-> !ccrOut[0])
    else $error("carry not cleared");
  AST_ZERO: assert property (ccrWrEn |-> ccrOut[2] == (regWrEnHigh ?
    {regWrDataHigh, regWrDataLow} == 0 : regWrDataLow == 0))
    else $error("zero flag wrong");
  AST_NEG: assert property (ccrWrEn |-> ccrOut[3] == (regWrEnHigh ?
    regWrDataHigh[WIDTH-1] : regWrDataLow[WIDTH-1]))
    else $error("negative flag wrong");
  AST_V64: assert property (regWrEnHigh |-> !ccrOut[1])
    else $error("overflow set on a 64-bit result");
  AST_WORDV: assert property ((accept && opWord[15:12] == 4'hc) |-> ##35 (ccrWrEn && !ccrOut[1]))
    else $error("overflow set by the word form");
  AST_ILLEGAL: assert property (illegal |-> !accept ##1 !busy)
    else $error("illegal encoding started a multiply");
endmodule

// ---- verification/imu_multiply_unit_test.sv ----
// Testbench of the multiply unit with its register file model.
`timescale 1ns/1ps
module imu_multiply_unit_test;
  logic clk, sys_rst, clkEn, issue, busy, accept, illegal, done, weL, weH, ccrWrEn;
  logic [15:0] opWord, extWord;
  logic [31:0] eaOperand, rdA, rdB, wdL, wdH;
  logic [4:0] ccrIn, ccrOut;
  logic [2:0] idxA, idxB, wiL, wiH;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  imu_multiply_unit imu_multiply_unit_inst (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .issue(issue), .opWord(opWord), .extWord(extWord), .eaOperand(eaOperand), .ccrIn(ccrIn),
    .regRdIdxA(idxA), .regRdDataA(rdA), .regRdIdxB(idxB), .regRdDataB(rdB), .busy(busy),
    .accept(accept), .illegal(illegal), .done(done), .regWrEnLow(weL), .regWrIdxLow(wiL),
    .regWrDataLow(wdL), .regWrEnHigh(weH), .regWrIdxHigh(wiH), .regWrDataHigh(wdH),
    .ccrWrEn(ccrWrEn), .ccrOut(ccrOut));
  imu_regfile_model imu_regfile_model_inst (.clk(clk), .rdIdxA(idxA), .rdDataA(rdA),
    .rdIdxB(idxB), .rdDataB(rdB), .wrEnLow(weL), .wrIdxLow(wiL), .wrDataLow(wdL),
    .wrEnHigh(weH), .wrIdxHigh(wiH), .wrDataHigh(wdH));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      close_out();
    end
  end
  // ==========================================
  // Shared tasks.
  task automatic close_out();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic mul(input logic [15:0] ow, input logic [15:0] ew, input logic [31:0] ea);
    logic w, s, big, v;
    logic [31:0] a, b;
    logic [63:0] p;
    logic [2:0] dl;
    int n;
    w = ow[15:12] == 4'hc;
    s = w ? ow[8] : ew[11];
    big = !w && ew[10];
    dl = w ? ow[11:9] : ew[14:12];
    a = imu_regfile_model_inst.dreg[dl];
    b = ow[5:3] == 3'h0 ? imu_regfile_model_inst.dreg[ow[2:0]] : ea;
    if (w) begin
      a = s ? {{16{a[15]}}, a[15:0]} : {16'h0, a[15:0]};
      b = s ? {{16{b[15]}}, b[15:0]} : {16'h0, b[15:0]};
    end
    if (s) p = $signed(a) * $signed(b);
    else p = a * b;
    v = !w && !big && (s ? p[63:32] != {32{p[31]}} : p[63:32] != 0);
    @(posedge clk);
    issue <= 1'b1;
    opWord <= ow;
    extWord <= ew;
    eaOperand <= ea;
    #1 chk(accept, 1, "accept");
    @(posedge clk);
    issue <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    chk({weL, ccrWrEn, weH}, {2'b11, big}, "strobes");
    chk(wiL, dl, "low index");
    chk(wdL, p[31:0], "low data");
    if (big) chk({wiH, wdH}, {ew[2:0], p[63:32]}, "high half");
    chk(ccrOut, {ccrIn[4], big ? p[63] : p[31], big ? p == 0 : p[31:0] == 0, v, 1'b0},
      "flags");
    @(posedge clk);
    #1;
  endtask
  // ==========================================
  // Scenarios.
  task automatic test_word();
    logic [5:0] eas [5] = '{6'h01, 6'h3c, 6'h3a, 6'h3b, 6'h28};
    imu_regfile_model_inst.dreg[1] = 32'h1234_8001;
    imu_regfile_model_inst.dreg[5] = 32'habcd_fffe;
    for (int i = 0; i < 10; i++) begin
      mul({4'hc, 3'h5, i[0] ? 3'h7 : 3'h3, eas[i / 2]}, 16'h0, 32'h7777_c003);
    end
  endtask
  task automatic test_long();
    imu_regfile_model_inst.dreg[3] = 32'h8000_0000;
    for (int k = 0; k < 16; k++) begin
      imu_regfile_model_inst.dreg[2] = k[0] ? 32'h0001_0000 : 32'hffff_fffd;
      mul(k[2] ? 16'h4c03 : 16'h4c3c, {1'b0, 3'h2, k[1], k[3], 7'h0, 3'h6}, 32'h2);
    end
  endtask
  task automatic test_zero();
    imu_regfile_model_inst.dreg[4] = 32'hffff_0000;
    ccrIn <= 5'h1f;
    mul(16'hc9fc, 16'h0, 32'h1234_5678);
    mul(16'h4c3c, 16'h4400, 32'h0);
  endtask
  task automatic test_bad();
    logic [15:0] ows [3] = '{16'hc1c8, 16'hc1fd, 16'h4c09};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      issue <= 1'b1;
      opWord <= ows[i];
      extWord <= 16'h1000;
      @(posedge clk);
      #1 chk({illegal, accept}, 2'b10, "bad encoding");
    end
    @(posedge clk);
    opWord <= 16'hc1fc;
    @(posedge clk);
    @(posedge clk);
    #1 chk({busy, accept, illegal}, 3'b100, "refused while busy");
    @(posedge clk);
    issue <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  initial begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    issue = 1'b0;
    opWord = 16'h0;
    extWord = 16'h0;
    eaOperand = 32'h0;
    ccrIn = 5'h0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    test_word();
    test_long();
    test_zero();
    test_bad();
    close_out();
  end
endmodule
bind imu_multiply_unit imu_mult_checker #(.WIDTH(WIDTH)) imu_mult_checker_inst (.clk(clk),
  .sys_rst(sys_rst), .opWord(opWord), .busy(busy), .accept(accept), .illegal(illegal),
  .done(done), .regWrEnLow(regWrEnLow), .regWrDataLow(regWrDataLow),
  .regWrEnHigh(regWrEnHigh), .regWrDataHigh(regWrDataHigh), .ccrWrEn(ccrWrEn),
  .ccrOut(ccrOut));
